/* File: rtl/t16_pkg.sv */
`default_nettype none
package t16_pkg;

    localparam int ADDR_W = 4;

    // Register byte locations on the slave port.
    localparam logic [3:0] OFS_CTRL_A   = 4'h0;
    localparam logic [3:0] OFS_CTRL_B   = 4'h1;
    localparam logic [3:0] OFS_CNT_LO   = 4'h2;
    localparam logic [3:0] OFS_CNT_HI   = 4'h3;
    localparam logic [3:0] OFS_CMPA_LO  = 4'h4;
    localparam logic [3:0] OFS_CMPA_HI  = 4'h5;
    localparam logic [3:0] OFS_CMPB_LO  = 4'h6;
    localparam logic [3:0] OFS_CMPB_HI  = 4'h7;
    localparam logic [3:0] OFS_CAP_LO   = 4'h8;
    localparam logic [3:0] OFS_CAP_HI   = 4'h9;
    localparam logic [3:0] OFS_FLAG     = 4'hA;
    localparam logic [3:0] OFS_MASK     = 4'hB;

    // Field positions.
    localparam int BIT_WGM_LO   = 0;
    localparam int BIT_WGM_HI   = 3;
    localparam int BIT_CS       = 0;
    localparam int BIT_CAP_SRC  = 5;
    localparam int BIT_CAP_EDGE = 6;
    localparam int BIT_NOISE    = 7;
    localparam int BIT_OVF      = 0;
    localparam int BIT_CMPA     = 1;
    localparam int BIT_CMPB     = 2;
    localparam int BIT_CAP      = 5;
    localparam logic [7:0] FLAG_USED = 8'h27;

    // Values after reset.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Counter limits.
    localparam logic [15:0] CNT_FLOOR = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;

    // Prescaler taps, as masks of a free-running ten-bit count.
    localparam logic [9:0] PRE_DIV8    = 10'h007;
    localparam logic [9:0] PRE_DIV64   = 10'h03F;
    localparam logic [9:0] PRE_DIV256  = 10'h0FF;
    localparam logic [9:0] PRE_DIV1024 = 10'h3FF;

    // Noise filter length in system clock samples.
    localparam int NOISE_LEN = 4;

    typedef enum logic [2:0] {
        CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
        CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
    } t16_clksel_t;

endpackage
`default_nettype wire

/* File: rtl/t16_core.sv */
`timescale 1ns/1ps
`default_nettype none
module t16_core (
    // System
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Avalon-MM slave
    input  wire logic [t16_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [7:0]                avs_writedata,
    output logic      [7:0]                avs_readdata,
    output logic                           avs_waitrequest,
    // Pins
    input  wire logic                      external_count_pin,
    input  wire logic                      capture_pin,
    input  wire logic                      comparator_out,
    // To waveform generator and interrupt controller
    output logic      [15:0]               timer_count,
    output logic                           cmp_match_a,
    output logic                           cmp_match_b,
    output logic                           wave_a_allowed,
    output logic                           at_floor,
    output logic                           at_max,
    output logic                           at_top,
    output logic      [7:0]                int_request
);
    import t16_pkg::*;

    logic        ack_q;
    logic [7:0]  rdata_q;
    logic [7:0]  temp_q;
    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [15:0] cnt_q;
    logic [15:0] cmpa_buf_q;
    logic [15:0] cmpb_buf_q;
    logic [15:0] cmpa_act_q;
    logic [15:0] cmpb_act_q;
    logic [15:0] cap_q;
    logic [7:0]  flag_q;
    logic [7:0]  mask_q;
    logic [9:0]  pre_q;
    logic        ext_s1, ext_s2, ext_s3;
    logic        cpin_s1, cpin_s2;
    logic        acmp_s1, acmp_s2;
    logic [NOISE_LEN-1:0] nc_q;
    logic        filt_q;
    logic        lvl_q;
    logic        match_a_q, match_b_q;
    logic [15:0] top;
    logic        tick;
    logic [7:0]  rmux;

    // Bus handshake: one wait cycle so that read data leave a flip-flop.
    wire req      = avs_read | avs_write;
    wire first    = req & ~ack_q;
    wire wr       = avs_write & ack_q;
    wire rd_first = avs_read & first;
    assign avs_waitrequest = first;
    assign avs_readdata    = rdata_q;

    wire wr_ctrl_a  = wr && avs_address == OFS_CTRL_A;
    wire wr_ctrl_b  = wr && avs_address == OFS_CTRL_B;
    wire wr_cnt_lo  = wr && avs_address == OFS_CNT_LO;
    wire wr_cmpa_lo = wr && avs_address == OFS_CMPA_LO;
    wire wr_cmpb_lo = wr && avs_address == OFS_CMPB_LO;
    wire wr_cap_lo  = wr && avs_address == OFS_CAP_LO;
    wire wr_flag    = wr && avs_address == OFS_FLAG;
    wire wr_mask    = wr && avs_address == OFS_MASK;
    wire wr_hi      = wr && (avs_address == OFS_CNT_HI
                          || avs_address == OFS_CMPA_HI
                          || avs_address == OFS_CMPB_HI
                          || avs_address == OFS_CAP_HI);
    wire rd_cnt_lo  = rd_first && avs_address == OFS_CNT_LO;
    wire rd_cap_lo  = rd_first && avs_address == OFS_CAP_LO;

    // Mode decode.
    wire [3:0] wgm = {ctrl_b_q[BIT_WGM_HI+1:BIT_WGM_HI],
                      ctrl_a_q[BIT_WGM_LO+1:BIT_WGM_LO]};
    wire [2:0] cs  = ctrl_b_q[BIT_CS+2:BIT_CS];
    wire cap_top   = wgm == 4'h8 || wgm == 4'hA || wgm == 4'hC
                  || wgm == 4'hE;
    wire pwm_mode  = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC
                    || wgm == 4'hD);
    // Compare A as PWM top cannot also shape output A.
    assign wave_a_allowed = !(wgm == 4'h9 || wgm == 4'hB
                           || wgm == 4'hF);

    always_comb begin
        case (wgm)
            4'h1, 4'h5: top = TOP_8BIT;
            4'h2, 4'h6: top = TOP_9BIT;
            4'h3, 4'h7: top = TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top = cmpa_act_q;
            4'h8, 4'hA, 4'hC, 4'hE: top = cap_q;
            default: top = CNT_MAX;
        endcase
    end

    assign timer_count = cnt_q;
    assign at_floor    = cnt_q == CNT_FLOOR;
    assign at_max      = cnt_q == CNT_MAX;
    assign at_top      = cnt_q == top;

    // Timer tick selection.
    wire ext_rise = ext_s2 & ~ext_s3;
    wire ext_fall = ~ext_s2 & ext_s3;
    always_comb begin
        case (t16_clksel_t'(cs))
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = (pre_q & PRE_DIV8) == PRE_DIV8;
            CS_DIV64:    tick = (pre_q & PRE_DIV64) == PRE_DIV64;
            CS_DIV256:   tick = (pre_q & PRE_DIV256) == PRE_DIV256;
            CS_DIV1024:  tick = pre_q == PRE_DIV1024;
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
            default:     tick = 1'b0;
        endcase
    end

    // Capture input path; disabled while the capture register is the top.
    wire cap_raw   = ctrl_b_q[BIT_CAP_SRC] ? acmp_s2 : cpin_s2;
    wire cap_lvl   = ctrl_b_q[BIT_NOISE] ? filt_q : cap_raw;
    wire cap_edge  = ctrl_b_q[BIT_CAP_EDGE] ? (cap_lvl & ~lvl_q)
                                            : (~cap_lvl & lvl_q);
    wire cap_event = cap_edge & ~cap_top;
    wire nc_ones   = &nc_q;
    wire nc_zeros  = ~|nc_q;

    // Compare results, continuous against the live counter.
    wire eq_a = cnt_q == cmpa_act_q;
    wire eq_b = cnt_q == cmpb_act_q;
    wire buf_load = !pwm_mode || (tick && cnt_q == top);

    // Flags: a hardware set wins over a write-one clear in the same cycle.
    logic [7:0] flag_set;
    always_comb begin
        flag_set = 8'h00;
        flag_set[BIT_OVF]  = tick && cnt_q == top;
        flag_set[BIT_CMPA] = match_a_q;
        flag_set[BIT_CMPB] = match_b_q;
        flag_set[BIT_CAP]  = cap_event;
    end
    wire [7:0] flag_clr = wr_flag ? avs_writedata : 8'h00;
    wire [7:0] flag_d   = ((flag_q & ~flag_clr) | flag_set) & FLAG_USED;
    assign int_request  = flag_q & mask_q;
    assign cmp_match_a  = match_a_q;
    assign cmp_match_b  = match_b_q;

    // Read mux; high bytes of counter and capture come from the holder.
    always_comb begin
        case (avs_address)
            OFS_CTRL_A:  rmux = ctrl_a_q;
            OFS_CTRL_B:  rmux = ctrl_b_q;
            OFS_CNT_LO:  rmux = cnt_q[7:0];
            OFS_CNT_HI:  rmux = temp_q;
            OFS_CMPA_LO: rmux = cmpa_buf_q[7:0];
            OFS_CMPA_HI: rmux = cmpa_buf_q[15:8];
            OFS_CMPB_LO: rmux = cmpb_buf_q[7:0];
            OFS_CMPB_HI: rmux = cmpb_buf_q[15:8];
            OFS_CAP_LO:  rmux = cap_q[7:0];
            OFS_CAP_HI:  rmux = temp_q;
            OFS_FLAG:    rmux = flag_q;
            OFS_MASK:    rmux = mask_q;
            default:     rmux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_q   <= 1'b0;
            rdata_q <= RST_BYTE;
        end else begin
            ack_q <= first;
            if (rd_first) begin
                rdata_q <= rmux;
            end
        end
    end

    // Shared high-byte holder; counter and capture low-byte reads load it on the request's first edge, high-byte writes on the acknowledged edge.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            temp_q <= RST_BYTE;
        end else if (wr_hi) begin
            temp_q <= avs_writedata;
        end else if (rd_cnt_lo) begin
            temp_q <= cnt_q[15:8];
        end else if (rd_cap_lo) begin
            temp_q <= cap_q[15:8];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_a_q <= RST_BYTE;
            ctrl_b_q <= RST_BYTE;
            mask_q   <= RST_BYTE;
            flag_q   <= RST_BYTE;
        end else begin
            if (wr_ctrl_a) begin
                ctrl_a_q <= avs_writedata;
            end
            if (wr_ctrl_b) begin
                ctrl_b_q <= avs_writedata;
            end
            if (wr_mask) begin
                mask_q <= avs_writedata & FLAG_USED;
            end
            flag_q <= flag_d;
        end
    end

    // Counter; a bus write outranks counting and wrapping.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_q <= RST_WORD;
        end else if (wr_cnt_lo) begin
            cnt_q <= {temp_q, avs_writedata};
        end else if (tick) begin
            cnt_q <= (cnt_q == top) ? CNT_FLOOR : cnt_q + 16'h0001;
        end
    end

    // Compare buffers load only on low-byte writes.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cmpa_buf_q <= RST_WORD;
            cmpb_buf_q <= RST_WORD;
            cmpa_act_q <= RST_WORD;
            cmpb_act_q <= RST_WORD;
            match_a_q  <= 1'b0;
            match_b_q  <= 1'b0;
        end else begin
            if (wr_cmpa_lo) begin
                cmpa_buf_q <= {temp_q, avs_writedata};
            end
            if (wr_cmpb_lo) begin
                cmpb_buf_q <= {temp_q, avs_writedata};
            end
            if (buf_load) begin
                cmpa_act_q <= cmpa_buf_q;
                cmpb_act_q <= cmpb_buf_q;
            end
            match_a_q <= tick & eq_a;
            match_b_q <= tick & eq_b;
        end
    end

    // Capture register; software may write it only while it defines top.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cap_q <= RST_WORD;
        end else if (wr_cap_lo && cap_top) begin
            cap_q <= {temp_q, avs_writedata};
        end else if (cap_event) begin
            cap_q <= cnt_q;
        end
    end

    // Pin synchronisers, prescaler and noise filter.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_s1  <= 1'b0;
            ext_s2  <= 1'b0;
            ext_s3  <= 1'b0;
            cpin_s1 <= 1'b0;
            cpin_s2 <= 1'b0;
            acmp_s1 <= 1'b0;
            acmp_s2 <= 1'b0;
            pre_q   <= 10'h000;
            nc_q    <= '0;
            filt_q  <= 1'b0;
            lvl_q   <= 1'b0;
        end else begin
            ext_s1  <= external_count_pin;
            ext_s2  <= ext_s1;
            ext_s3  <= ext_s2;
            cpin_s1 <= capture_pin;
            cpin_s2 <= cpin_s1;
            acmp_s1 <= comparator_out;
            acmp_s2 <= acmp_s1;
            pre_q   <= pre_q + 10'h001;
            nc_q    <= {nc_q[NOISE_LEN-2:0], cap_raw};
            if (nc_ones) begin
                filt_q <= 1'b1;
            end else if (nc_zeros) begin
                filt_q <= 1'b0;
            end
            lvl_q <= cap_lvl;
        end
    end

    // The master can take its answer exactly one edge after asking.
    a_bus_one_wait: assert property (
        @(posedge sys_clk) disable iff (reset)
        first |=> !avs_waitrequest ##0 ack_q)
        else $error("waitrequest did not fall after one cycle");

    a_low_write_commit: assert property (
        @(posedge sys_clk) disable iff (reset)
        wr_cnt_lo |=> cnt_q == {$past(temp_q), $past(avs_writedata)})
        else $error("low byte write did not commit the full word");

    a_low_read_copy: assert property (
        @(posedge sys_clk) disable iff (reset)
        rd_cnt_lo |=> temp_q == $past(cnt_q[15:8])
                      ##0 avs_readdata == $past(cnt_q[7:0]))
        else $error("low byte read did not load the holding register");

    a_high_write_only: assert property (
        @(posedge sys_clk) disable iff (reset)
        wr_hi |=> $stable(cmpa_buf_q) && $stable(cmpb_buf_q)
                  && temp_q == $past(avs_writedata))
        else $error("high byte write changed a word register");

    a_cmp_high_read: assert property (
        @(posedge sys_clk) disable iff (reset)
        (rd_first && avs_address == OFS_CMPA_HI)
        |=> avs_readdata == $past(cmpa_buf_q[15:8]) && $stable(temp_q))
        else $error("compare high read used the holding register");

    a_fixed_top: assert property (
        @(posedge sys_clk) disable iff (reset)
        (wgm == 4'h2 && tick && cnt_q == TOP_9BIT && !wr_cnt_lo)
        |=> cnt_q == CNT_FLOOR)
        else $error("nine bit mode did not wrap at its top");

    a_match_flag: assert property (
        @(posedge sys_clk) disable iff (reset)
        (tick && eq_b) |=> ##1 flag_q[BIT_CMPB])
        else $error("compare match B did not set its flag");

    a_mask_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        (flag_q[BIT_OVF] && !mask_q[BIT_OVF]) |-> !int_request[BIT_OVF])
        else $error("masked request reached the output");

    a_stopped_hold: assert property (
        @(posedge sys_clk) disable iff (reset)
        (cs == 3'h0 && !wr_cnt_lo) |=> $stable(cnt_q))
        else $error("counter moved with no clock source");

    a_cap_lock: assert property (
        @(posedge sys_clk) disable iff (reset)
        (wr_cap_lo && !cap_top && !cap_event) |=> $stable(cap_q))
        else $error("capture register written outside top modes");

endmodule // t16_core
`default_nettype wire

/* File: test/t16_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module t16_cpu_model (
    // Clock
    input  wire logic                  sys_clk,
    // Avalon-MM master side
    output logic [t16_pkg::ADDR_W-1:0] avs_address,
    output logic                       avs_read,
    output logic                       avs_write,
    output logic [7:0]                 avs_writedata,
    input  wire logic [7:0]            avs_readdata,
    input  wire logic                  avs_waitrequest,
    // Requests that never got an answer
    output int                         stalls
);
    import t16_pkg::*;

    initial begin
        avs_address   = '0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 8'h00;
        stalls        = 0;
    end

    // Idle write data shows the inverse so a stale byte never passes.
    task automatic bus(input logic [ADDR_W-1:0] a, input logic rd,
                       input logic [7:0] wd, output logic [7:0] q);
        int n;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_read      <= rd;
        avs_write     <= ~rd;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) stalls++;
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_writedata <= ~wd;
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(a, 1'b0, d, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
        bus(a, 1'b1, 8'h00, q);
    endtask

    // Pairs run to completion with nothing interleaved.
    task automatic wr16(input logic [ADDR_W-1:0] hi, lo,
                        input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(lo, v[7:0]);
    endtask

    task automatic rd16(input logic [ADDR_W-1:0] lo, hi,
                        output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(hi, v[15:8]);
    endtask
endmodule // t16_cpu_model
`default_nettype wire

/* File: test/timer16_byte_access_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module timer16_byte_access_core_tb_top;
    import t16_pkg::*;

    logic                  sys_clk;
    logic                  reset;
    logic [ADDR_W-1:0]     avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [7:0]            avs_writedata;
    logic [7:0]            avs_readdata;
    logic                  avs_waitrequest;
    logic                  external_count_pin;
    logic                  capture_pin;
    logic                  comparator_out;
    logic [15:0]           timer_count;
    logic                  cmp_match_a;
    logic                  cmp_match_b;
    logic                  wave_a_allowed;
    logic                  at_floor;
    logic                  at_max;
    logic                  at_top;
    logic [7:0]            int_request;
    int                    stalls;
    int                    mismatches;
    int                    tests_run;
    int                    i;
    logic [7:0]            b;
    logic [15:0]           w;

    t16_core DUT (.sys_clk(sys_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_count_pin(external_count_pin),
        .capture_pin(capture_pin), .comparator_out(comparator_out),
        .timer_count(timer_count), .cmp_match_a(cmp_match_a),
        .cmp_match_b(cmp_match_b), .wave_a_allowed(wave_a_allowed),
        .at_floor(at_floor), .at_max(at_max), .at_top(at_top),
        .int_request(int_request));

    t16_cpu_model cpu (.sys_clk(sys_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stalls(stalls));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        if (stalls != 0) mismatches++;
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [7:0] q;
        cpu.rd(a, q);
        chk({8'h00, q}, {8'h00, e});
    endtask

    task automatic r16c(input logic [ADDR_W-1:0] lo, hi,
                        input logic [15:0] e);
        logic [15:0] v;
        cpu.rd16(lo, hi, v);
        chk(v, e);
    endtask

    // Selector: 0 top, 1 floor, 2 capture request, 3 match A, 4 match B.
    task automatic wait_on(input int s);
        int n;
        n = 0;
        while (!(s == 0 ? at_top === 1'b1 : s == 1 ? at_floor === 1'b1
                 : s == 2 ? int_request[BIT_CAP] === 1'b1
                 : s == 3 ? cmp_match_a === 1'b1 : cmp_match_b === 1'b1)) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 500) begin
                mismatches++;
                $display("BAD %0t wait expired", $time);
                wrap_up();
            end
        end
    endtask

    task automatic pulse3();
        repeat (3) begin
            repeat (4) @(posedge sys_clk);
            external_count_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            external_count_pin <= 1'b0;
        end
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        reset = 1'b1;
        external_count_pin = 1'b0;
        capture_pin = 1'b0;
        comparator_out = 1'b0;
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(timer_count, RST_WORD);
        chk({15'h0000, at_floor}, 16'h0001);
        // Every location, mapped or not, reads zero after reset.
        for (i = 0; i < 16; i++) rdc(4'(i), RST_BYTE);
        cpu.wr(4'hD, 8'h5A);
        rdc(4'hD, 8'h00);
        cpu.wr(OFS_CTRL_B, 8'hC0);
        rdc(OFS_CTRL_B, 8'hC0);
        cpu.wr(OFS_CTRL_A, 8'h03);
        rdc(OFS_CTRL_A, 8'h03);
        cpu.wr(OFS_CTRL_A, 8'h00);
        cpu.wr(OFS_CTRL_B, 8'h00);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h1234);
        chk(timer_count, 16'h1234);
        cpu.wr(OFS_CNT_HI, 8'h56);
        chk(timer_count, 16'h1234);
        cpu.wr(OFS_CNT_LO, 8'h78);
        chk(timer_count, 16'h5678);
        cpu.wr(OFS_CNT_HI, 8'hAA);
        r16c(OFS_CNT_LO, OFS_CNT_HI, 16'h5678);
        cpu.wr16(OFS_CMPA_HI, OFS_CMPA_LO, 16'h1357);
        cpu.wr(OFS_CAP_HI, 8'h99);
        rdc(OFS_CMPA_HI, 8'h13);
        rdc(OFS_CNT_HI, 8'h99);
        // One holding byte loaded once serves two low writes.
        cpu.wr(OFS_CNT_HI, 8'h00);
        cpu.wr(OFS_CMPA_LO, 8'h10);
        cpu.wr(OFS_CMPB_LO, 8'h20);
        r16c(OFS_CMPA_LO, OFS_CMPA_HI, 16'h0010);
        r16c(OFS_CMPB_LO, OFS_CMPB_HI, 16'h0020);
        cpu.wr16(OFS_CAP_HI, OFS_CAP_LO, 16'hBEEF);
        r16c(OFS_CAP_LO, OFS_CAP_HI, 16'h0000);
        cpu.wr(OFS_CTRL_A, 8'h01);
        cpu.wr(OFS_CTRL_B, 8'h10);
        chk({15'h0000, wave_a_allowed}, 16'h0000);
        cpu.wr(OFS_CTRL_A, 8'h03);
        cpu.wr(OFS_CTRL_B, 8'h10);
        chk({15'h0000, wave_a_allowed}, 16'h0000);
        cpu.wr(OFS_CTRL_B, 8'h18);
        chk({15'h0000, wave_a_allowed}, 16'h0000);
        cpu.wr(OFS_CTRL_A, 8'h00);
        chk({15'h0000, wave_a_allowed}, 16'h0001);
        cpu.wr16(OFS_CAP_HI, OFS_CAP_LO, 16'h0040);
        r16c(OFS_CAP_LO, OFS_CAP_HI, 16'h0040);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0000);
        cpu.wr(OFS_CTRL_B, 8'h19);
        wait_on(0);
        chk(timer_count, 16'h0040);
        wait_on(1);
        chk(timer_count, CNT_FLOOR);
        cpu.wr(OFS_CTRL_B, 8'h18);
        rdc(OFS_FLAG, 8'h07);
        chk({8'h00, int_request}, 16'h0000);
        cpu.wr(OFS_MASK, FLAG_USED);
        chk({8'h00, int_request}, 16'h0007);
        cpu.wr(OFS_FLAG, 8'h02);
        rdc(OFS_FLAG, 8'h05);
        chk({8'h00, int_request}, 16'h0005);
        cpu.wr(OFS_FLAG, 8'hFF);
        cpu.wr(OFS_CTRL_B, 8'h00);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, CNT_MAX);
        chk({14'h0000, at_max, at_top}, 16'h0003);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0123);
        cpu.wr(OFS_CTRL_B, 8'h40);
        @(posedge sys_clk);
        capture_pin <= 1'b1;
        wait_on(2);
        r16c(OFS_CAP_LO, OFS_CAP_HI, 16'h0123);
        @(posedge sys_clk);
        comparator_out <= 1'b1;
        // A source change may itself capture, so the flag is cleared.
        cpu.wr(OFS_CTRL_B, 8'h20);
        cpu.wr(OFS_FLAG, 8'h20);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0456);
        @(posedge sys_clk);
        comparator_out <= 1'b0;
        wait_on(2);
        r16c(OFS_CAP_LO, OFS_CAP_HI, 16'h0456);
        cpu.wr(OFS_CTRL_B, 8'h07);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h0000);
        pulse3();
        chk(timer_count, 16'h0003);
        cpu.wr(OFS_CTRL_B, 8'h00);
        pulse3();
        chk(timer_count, 16'h0003);
        // Nine-bit mode: compare A stays buffered until the wrap at top.
        cpu.wr(OFS_CTRL_A, 8'h02);
        cpu.wr16(OFS_CMPA_HI, OFS_CMPA_LO, 16'h01FC);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h01F8);
        cpu.wr(OFS_FLAG, 8'hFF);
        cpu.wr(OFS_CTRL_B, 8'h01);
        wait_on(0);
        chk(timer_count, TOP_9BIT);
        wait_on(1);
        rdc(OFS_FLAG, 8'h01);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h01F8);
        wait_on(3);
        chk(timer_count, 16'h01FD);
        @(posedge sys_clk);
        #1;
        chk({15'h0000, cmp_match_a}, 16'h0000);
        wait_on(4);
        chk(timer_count, 16'h0021);
        cpu.wr(OFS_CTRL_B, 8'h01);
        cpu.wr16(OFS_CNT_HI, OFS_CNT_LO, 16'h1234);
        chk(timer_count, 16'h1234);
        wrap_up();
    end
endmodule // timer16_byte_access_core_tb_top
`default_nettype wire
